// ==== rtl/rsd_pkg.sv ====
// Shared constants and types for the reset strap and debug pin selector
package rsd_pkg;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int RSD_CLK_HZ = 50_000_000;
   localparam int RSD_SAMPLE_DELAY_NS = 1500;
   // Rounded up so the pins have settled for at least the full delay
   localparam int RSD_SAMPLE_CYCLES =
      (RSD_SAMPLE_DELAY_NS * (RSD_CLK_HZ / 1_000_000) + 999) / 1000;

   // ------------------------------------------------------------
   // Widths and codes
   // ------------------------------------------------------------
   localparam int RSD_PT_W = 8;
   localparam int RSD_STRAP_W = 3;
   localparam logic [2:0] RSD_CODE_HIZ = 3'h7;
   localparam logic [2:0] RSD_CODE_CLK = 3'h2;
   localparam logic [7:0] RSD_CFG_RST = 8'h00;

   // Debug clock tap positions in the divider counter
   localparam int RSD_TAP_FAST = 0;
   localparam int RSD_TAP_HALF = 1;
   localparam int RSD_TAP_QUART = 2;
   localparam int RSD_TAP_EIGHTH = 3;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      RSD_ST_HOLD = 4'h1,
      RSD_ST_WAIT = 4'h2,
      RSD_ST_CAPT = 4'h4,
      RSD_ST_RUN = 4'h8
   } rsd_state_type;

   typedef struct packed {
      logic [7:0] cfg;
      logic [2:0] mode;
   } rsd_capture_type;
endpackage

// ==== rtl/rsd_strap_debug.sv ====
// Strap capture after reset and debug test-point output selection
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Test points high impedance while reset asserted
// - Sample test points 1.5 us after release
// - Hold captured test points as configuration
// - Sample scan-out straps then drive them
// - Captured strap code picks test-point mode
// - Weak pull-ups default strap code to 111
// - Code 010 drives divided debug clocks
// - Software may rewrite test-point mode once straps are captured
module rsd_strap_debug
   import rsd_pkg::*;
#(
   parameter int SAMPLE_CYCLES = RSD_SAMPLE_CYCLES
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // Debug test-point pins
   input wire logic [7:0] debug_point_pins_in,
   output logic [7:0] debug_point_pins_out,
   output logic [7:0] debug_point_pins_oe_n_out,
   // Scan-out strap pins
   input wire logic [2:0] scan_out_strap_pins_in,
   output logic [2:0] scan_out_strap_pins_out,
   output logic [2:0] scan_out_strap_pins_oe_n_out,
   output logic strap_pullup_en_out,
   // Normal scan-out data once straps are released
   input wire logic [2:0] scan_out_data_in,
   // Software mode rewrite
   input wire logic mode_wr_in,
   input wire logic [2:0] mode_wr_data_in,
   // Captured state
   output logic [7:0] config_out,
   output logic [2:0] strap_code_out,
   output logic [2:0] pt_mode_out,
   output logic captured_out
);

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   localparam int CW = $clog2(SAMPLE_CYCLES + 1);
   generate
      if (SAMPLE_CYCLES < 1) begin : g_bad_cycles
         $error("SAMPLE_CYCLES must be at least 1");
      end
      // The slowest debug clock must still fit the divider
      if (RSD_TAP_EIGHTH > 3) begin : g_bad_tap
         $error("divider too narrow for the slowest tap");
      end
   endgenerate

   // ------------------------------------------------------------
   // Sequencer state
   // ------------------------------------------------------------
   rsd_state_type state_q, state_d;
   logic [CW-1:0] cnt_q, cnt_d;
   rsd_capture_type cap_q, cap_d;
   logic [2:0] mode_q, mode_d;
   logic [3:0] div_q, div_d;
   logic [7:0] pt_out_q, pt_out_d;
   logic [7:0] pt_oen_q, pt_oen_d;
   logic [2:0] so_out_q, so_out_d;
   logic [2:0] so_oen_q, so_oen_d;
   logic done_q, done_d;
   logic pullup_q, pullup_d;
   wire logic [7:0] clk_pt;

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      cap_d = cap_q;
      mode_d = mode_q;
      done_d = done_q;
      unique case (state_q)
         RSD_ST_HOLD: begin
            // First edge after release starts the delay count
            cnt_d = '0;
            state_d = RSD_ST_WAIT;
         end
         RSD_ST_WAIT: begin
            cnt_d = cnt_q + CW'(1);
            if (cnt_q == CW'(SAMPLE_CYCLES - 1)) begin
               state_d = RSD_ST_CAPT;
            end
         end
         RSD_ST_CAPT: begin
            cap_d.cfg = debug_point_pins_in;
            cap_d.mode = scan_out_strap_pins_in;
            mode_d = scan_out_strap_pins_in;
            done_d = 1'b1;
            state_d = RSD_ST_RUN;
         end
         RSD_ST_RUN: begin
            // Captures stay frozen; only reset reopens sampling
            if (mode_wr_in) begin
               mode_d = mode_wr_data_in;
            end
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_q <= RSD_ST_HOLD;
         cnt_q <= '0;
         cap_q <= '{cfg: RSD_CFG_RST, mode: RSD_CODE_HIZ};
         mode_q <= RSD_CODE_HIZ;
         done_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         cap_q <= cap_d;
         mode_q <= mode_d;
         done_q <= done_d;
      end
   end

   // ------------------------------------------------------------
   // Debug clock divider
   // ------------------------------------------------------------
   // Free-running from reset so every tap has a defined phase by the
   // time clock mode is entered
   always_comb begin
      div_d = div_q + 4'h1;
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         div_q <= 4'h0;
      end else begin
         div_q <= div_d;
      end
   end

   // Divider tap behind each test point in clock mode
   function automatic int tap_of(input int pt);
      int tap;
      tap = RSD_TAP_FAST;
      if (pt == 1) begin
         tap = RSD_TAP_HALF;
      end
      if (pt == 4) begin
         tap = RSD_TAP_QUART;
      end
      if (pt == 2) begin
         tap = RSD_TAP_EIGHTH;
      end
      return tap;
   endfunction

   // Points 3, 6 and 7 carry no clock and stay low
   localparam logic [7:0] CLK_PTS = 8'h37;

   generate
      for (genvar i = 0; i < 8; i++) begin : g_pt
         assign clk_pt[i] = CLK_PTS[i] & div_q[tap_of(i)];
      end
   endgenerate

   // ------------------------------------------------------------
   // Pin drive
   // ------------------------------------------------------------
   // Taps keep the 8:4:2:1 ratios between the debug clocks; the
   // absolute rates follow the core clock since no faster one exists.
   always_comb begin
      pt_out_d = 8'h00;
      pt_oen_d = 8'hff;
      so_out_d = 3'h0;
      so_oen_d = 3'h7;
      if (state_q == RSD_ST_RUN) begin
         so_out_d = scan_out_data_in;
         so_oen_d = 3'h0;
         if (mode_q == RSD_CODE_CLK) begin
            pt_oen_d = 8'h00;
            pt_out_d = clk_pt;
         end
         // Code 111 and unlisted codes leave the points floating
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pt_out_q <= 8'h00;
         pt_oen_q <= 8'hff;
         so_out_q <= 3'h0;
         so_oen_q <= 3'h7;
      end else begin
         pt_out_q <= pt_out_d;
         pt_oen_q <= pt_oen_d;
         so_out_q <= so_out_d;
         so_oen_q <= so_oen_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Pull-ups stay on so an unstrapped board reads the idle code;
   // they are weak, so the drive after capture overrides them
   always_comb begin
      pullup_d = 1'b1;
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pullup_q <= 1'b1;
      end else begin
         pullup_q <= pullup_d;
      end
   end

   assign debug_point_pins_out = pt_out_q;
   assign debug_point_pins_oe_n_out = pt_oen_q;
   assign scan_out_strap_pins_out = so_out_q;
   assign scan_out_strap_pins_oe_n_out = so_oen_q;
   assign strap_pullup_en_out = pullup_q;
   assign config_out = cap_q.cfg;
   assign strap_code_out = cap_q.mode;
   assign pt_mode_out = mode_q;
   assign captured_out = done_q;

endmodule

`default_nettype wire

// ==== verif/rsd_monitor.sv ====
// Property checker for the strap capture block
`timescale 1ns/1ps
`default_nettype none
module rsd_monitor
   import rsd_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // Pins
   input wire logic [7:0] debug_point_pins_in,
   input wire logic [7:0] debug_point_pins_out,
   input wire logic [7:0] debug_point_pins_oe_n_out,
   input wire logic [2:0] scan_out_strap_pins_in,
   input wire logic [2:0] scan_out_strap_pins_oe_n_out,
   input wire logic strap_pullup_en_out,
   // Mode and captures
   input wire logic mode_wr_in,
   input wire logic [2:0] mode_wr_data_in,
   input wire logic [7:0] config_out,
   input wire logic [2:0] strap_code_out,
   input wire logic [2:0] pt_mode_out,
   input wire logic captured_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   AST_HIZ: assert property (!captured_out |->
      debug_point_pins_oe_n_out == 8'hff) else $error("early drive");
   AST_HOLD: assert property (captured_out |=> captured_out &&
      $stable(config_out) && $stable(strap_code_out)) else $error("hold");
   AST_CFG: assert property ($rose(captured_out) |->
      config_out == $past(debug_point_pins_in)) else $error("config");
   AST_CODE: assert property ($rose(captured_out) |->
      strap_code_out == $past(scan_out_strap_pins_in) &&
      pt_mode_out == strap_code_out) else $error("strap code");
   AST_DRV: assert property (captured_out |=>
      scan_out_strap_pins_oe_n_out == 3'h0) else $error("strap drive");
   AST_PUP: assert property (strap_pullup_en_out)
      else $error("pull-up off");
   AST_CLK: assert property (pt_mode_out == RSD_CODE_CLK [*2] |=>
      debug_point_pins_oe_n_out == 8'h00 &&
      debug_point_pins_out[0] != $past(debug_point_pins_out[0]) &&
      (debug_point_pins_out & 8'hc8) == 8'h00) else $error("clocks");
   AST_OFF: assert property (pt_mode_out != RSD_CODE_CLK |=>
      debug_point_pins_oe_n_out == 8'hff) else $error("not hi-z");
   AST_WR: assert property (captured_out && mode_wr_in |=>
      pt_mode_out == $past(mode_wr_data_in)) else $error("mode write");
   cover property ($rose(captured_out));
   cover property (pt_mode_out == RSD_CODE_CLK);
   cover property (captured_out && mode_wr_in);
endmodule
bind rsd_strap_debug rsd_monitor u_mon (.*);
`default_nettype wire

// ==== verif/rsd_board.sv ====
// Board strap resistors and resolved pin levels
`timescale 1ns/1ps
`default_nettype none
module rsd_board (
   // Strap set-up, jumper bit low pulls down
   input wire logic [7:0] strap_in,
   input wire logic [2:0] jumper_in,
   // Device drive
   input wire logic [7:0] pt_drv_in,
   input wire logic [7:0] pt_oe_n_in,
   input wire logic [2:0] so_drv_in,
   input wire logic [2:0] so_oe_n_in,
   input wire logic pullup_in,
   // Resolved levels
   output logic [7:0] pt_out,
   output logic [2:0] so_out
);
   logic [2:0] rel;
   // Unpulled open strap floats: show inverse of last drive
   assign rel = jumper_in & (pullup_in ? 3'h7 : ~so_drv_in);
   assign pt_out = (pt_oe_n_in & strap_in) | (~pt_oe_n_in & pt_drv_in);
   assign so_out = (so_oe_n_in & rel) | (~so_oe_n_in & so_drv_in);
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench for the strap capture block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import rsd_pkg::*;
   logic clk_in, resetn_in, mode_wr_in, strap_pullup_en_out, captured_out;
   logic [7:0] debug_point_pins_in, debug_point_pins_out, config_out;
   logic [7:0] debug_point_pins_oe_n_out, strap;
   logic [2:0] scan_out_strap_pins_in, scan_out_strap_pins_out, jumper;
   logic [2:0] scan_out_strap_pins_oe_n_out, scan_out_data_in;
   logic [2:0] mode_wr_data_in, strap_code_out, pt_mode_out;
   int fail_count = 0;
   int checks = 0;
   rsd_strap_debug #(.SAMPLE_CYCLES(4)) dut (.*);
   rsd_board board (.strap_in(strap), .jumper_in(jumper),
      .pt_drv_in(debug_point_pins_out), .pt_oe_n_in(debug_point_pins_oe_n_out),
      .so_drv_in(scan_out_strap_pins_out), .pullup_in(strap_pullup_en_out),
      .so_oe_n_in(scan_out_strap_pins_oe_n_out),
      .pt_out(debug_point_pins_in), .so_out(scan_out_strap_pins_in));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic boot(input logic [7:0] pat, input logic [2:0] jmp);
      int n;
      logic [7:0] oen;
      oen = (jmp == RSD_CODE_CLK) ? 8'h00 : 8'hff;
      resetn_in = 0;
      strap = pat;
      jumper = jmp;
      repeat (2) @(negedge clk_in);
      chk(debug_point_pins_oe_n_out, 8'hff);
      chk({5'h0, scan_out_strap_pins_oe_n_out}, 8'h07);
      chk({7'h0, strap_pullup_en_out}, 8'h01);
      chk({5'h0, strap_code_out}, 8'h07);
      resetn_in = 1;
      for (n = 0; n < 20 && captured_out !== 1'b1; n++) @(negedge clk_in);
      if (n == 20) begin
         fail_count++;
         results();
      end
      chk(config_out, pat);
      chk({5'h0, strap_code_out}, {5'h0, jmp});
      chk({5'h0, pt_mode_out}, {5'h0, jmp});
      strap = ~pat;
      jumper = ~jmp;
      scan_out_data_in = ~jmp;
      repeat (3) @(negedge clk_in);
      chk(config_out, pat);
      chk({5'h0, strap_code_out}, {5'h0, jmp});
      chk({5'h0, scan_out_strap_pins_oe_n_out}, 8'h00);
      chk({5'h0, scan_out_strap_pins_in}, {5'h0, ~jmp});
      chk(debug_point_pins_oe_n_out, oen);
      $display("boot %h %h done", pat, jmp);
   endtask
   task automatic clocks();
      logic a;
      chk(debug_point_pins_oe_n_out, 8'h00);
      a = debug_point_pins_in[0];
      @(negedge clk_in);
      chk(debug_point_pins_in & 8'hc8, 8'h00);
      chk({7'h0, debug_point_pins_in[0] ^ a}, 8'h01);
      $display("clocks done");
   endtask
   task automatic wr(input logic [2:0] code);
      logic [7:0] oen;
      oen = (code == RSD_CODE_CLK) ? 8'h00 : 8'hff;
      mode_wr_in = 1;
      mode_wr_data_in = code;
      @(negedge clk_in);
      mode_wr_in = 0;
      repeat (2) @(negedge clk_in);
      chk({5'h0, pt_mode_out}, {5'h0, code});
      chk(debug_point_pins_oe_n_out, oen);
      $display("write %h done", code);
   endtask
   initial begin
      clk_in = 0;
      forever #10 clk_in = ~clk_in;
   end
   initial begin
      resetn_in = 0;
      mode_wr_in = 0;
      mode_wr_data_in = 3'h0;
      scan_out_data_in = 3'h5;
      boot(8'ha5, RSD_CODE_HIZ);
      boot(8'h3c, RSD_CODE_CLK);
      clocks();
      wr(RSD_CODE_HIZ);
      wr(RSD_CODE_CLK);
      clocks();
      results();
   end
endmodule
`default_nettype wire
